/* rtl/tss_defs.svh */
// Constants for the turnstile supervisor: settings, defaults and timing.
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define TSS_REG_FLAGS 8'h00
`define TSS_REG_SEGS 8'h04
`define TSS_REG_BOOKZONE 8'h08
`define TSS_REG_EMAREA 8'h0C
`define TSS_REG_EMTIME 8'h10
`define TSS_REG_BUZZTIME 8'h14
`define TSS_REG_STOPTIME 8'h18
`define TSS_REG_BREAKSTEPS 8'h1C
`define TSS_REG_REDUNTIME 8'h20
`define TSS_REG_RESTORETIME 8'h24
`define TSS_REG_RECLOSE 8'h28
`define TSS_REG_STATUS 8'h2C
`define TSS_REG_CMD 8'h30

// -----------------------------------------------------------------------
// Flag register bit positions
// -----------------------------------------------------------------------
`define TSS_F_REDBOOK 0
`define TSS_F_SEMZONE 1
`define TSS_F_STARTROT 2
`define TSS_F_RADARONLY 3
`define TSS_F_FOLDING 4
`define TSS_F_BRAKELOCK 5
`define TSS_F_NCHARPOON 6
`define TSS_F_NCEMERG 7
`define TSS_F_THREEWING 8
`define TSS_F_RINGMASTER 9
`define TSS_F_RING19200 10

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define TSS_FLAGS_RST 16'h0600
`define TSS_SEGS_RST 16'h0004
`define TSS_BOOKZONE_RST 16'h02BC
`define TSS_EMAREA_RST 16'h01F4
`define TSS_EMTIME_RST 16'h000A
`define TSS_BUZZTIME_RST 16'h000F
`define TSS_STOPTIME_RST 16'h000A
`define TSS_BREAKSTEPS_RST 16'h0064
`define TSS_REDUNTIME_RST 16'h0000
`define TSS_RESTORETIME_RST 16'h001E
`define TSS_RECLOSE_RST 16'h000A
`define TSS_STOP_MIN 16'h000A

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define TSS_CLK_HZ 125000000
`define TSS_UNIT_50MS_NS 50000000
`define TSS_CLK_NS 8
`define TSS_TICK_CYC (`TSS_UNIT_50MS_NS / `TSS_CLK_NS)

`endif

/* rtl/tss_pkg.sv */
// Types for the turnstile supervisor.
package tss_pkg;

    typedef enum logic [2:0] {
        TSS_INIT,
        TSS_IDLE,
        TSS_RUN,
        TSS_EDGESTOP,
        TSS_FOLDSTOP,
        TSS_UNLOCKED
    } tss_state_t;

    typedef struct packed {
        logic transitBtn;
        logic radar;
        logic emergBtn;
        logic edgeSafety;
        logic doorDown;
        logic blocked;
        logic moveCmd;
        logic dirCw;
    } tss_in_t;

    typedef struct packed {
        logic semGreen;
        logic semRed;
        logic buzzer;
        logic breakOut;
        logic brake;
        logic harpoon;
        logic motorRun;
        logic motorCcw;
        logic emergArmed;
        logic bookAccept;
    } tss_out_t;

endpackage : tss_pkg

/* rtl/turnstile_supervisor.sv */
// Supervisory logic of a revolving-door turnstile.
// Functional notes
// - Reduced booking: accept only inside zone
// - Zone counted from segment start, default 700
// - Semaphore green when booking possible, else red
// - Revolution split into segments, default four
// - Emergency area plus/minus 500 steps of rest
// - Emergency armed after 10 s inside area
// - Emergency input polarity NC or NO
// - Forward-edge trip sounds buzzer 1.5 s
// - Edge stop 1 s, then reverse
// - Edge stop never shorter than 1 s
// - Hand movement beyond 100 steps flags break
// - Emergency unlock auto-restores after 30 s
// - Startup rotation or resume previous mode
// - Radar-only ignores transit buttons
// - Door knocked down stops; brake optional
// - Harpoon drive polarity selectable NC
// - Three-wing always turns counterclockwise; an edge stop still reverses it to clockwise
// - Redundancy wait before emergency release
// - Ring master at 19200 baud, always set
// - Blocked for re-closure time reverses
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tss_defs.svh"

module turnstile_supervisor #(
    parameter int TICK_CYC = `TSS_TICK_CYC,
    parameter int POS_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Position and field inputs
    input wire logic [POS_W-1:0] position,
    input wire logic [POS_W-1:0] segLength,
    input wire logic atRest,
    input wire logic savedRotMode,
    input wire tss_pkg::tss_in_t fieldIn,
    // Outputs to the booth
    output tss_pkg::tss_out_t ctrlOut,
    output logic transitStart
);
    import tss_pkg::*;

    // -------------------------------------------------------------------
    // Settings registers
    // -------------------------------------------------------------------
    logic [15:0] flags, segs, bookZone, emArea, emTime, buzzTime;
    logic [15:0] stopTime, breakSteps, redunTime, restoreTime, reclose;
    logic rotOnRequest;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= `TSS_FLAGS_RST;
            segs <= `TSS_SEGS_RST;
            bookZone <= `TSS_BOOKZONE_RST;
            emArea <= `TSS_EMAREA_RST;
            emTime <= `TSS_EMTIME_RST;
            buzzTime <= `TSS_BUZZTIME_RST;
            stopTime <= `TSS_STOPTIME_RST;
            breakSteps <= `TSS_BREAKSTEPS_RST;
            redunTime <= `TSS_REDUNTIME_RST;
            restoreTime <= `TSS_RESTORETIME_RST;
            reclose <= `TSS_RECLOSE_RST;
        end else if (regWr) begin
            case (regAddr)
                `TSS_REG_FLAGS: begin
                    // Ring master and 19200 baud stay set.
                    flags <= regWdata[15:0] | `TSS_FLAGS_RST;
                end
                `TSS_REG_SEGS: segs <= regWdata[15:0];
                `TSS_REG_BOOKZONE: bookZone <= regWdata[15:0];
                `TSS_REG_EMAREA: emArea <= regWdata[15:0];
                `TSS_REG_EMTIME: emTime <= regWdata[15:0];
                `TSS_REG_BUZZTIME: buzzTime <= regWdata[15:0];
                `TSS_REG_STOPTIME: stopTime <= regWdata[15:0];
                `TSS_REG_BREAKSTEPS: breakSteps <= regWdata[15:0];
                `TSS_REG_REDUNTIME: redunTime <= regWdata[15:0];
                `TSS_REG_RESTORETIME: restoreTime <= regWdata[15:0];
                `TSS_REG_RECLOSE: reclose <= regWdata[15:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Common time base
    // -------------------------------------------------------------------
    // One 50 ms tick; tenths and seconds are divided down from it so all
    // timers stay in phase with each other.
    logic [31:0] tickCnt;
    logic [1:0] tenthDiv;
    logic [4:0] secDiv;
    logic tick50, tickTenth, tickSec;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt <= 32'h0;
            tenthDiv <= 2'h0;
            secDiv <= 5'h0;
            tick50 <= 1'b0;
            tickTenth <= 1'b0;
            tickSec <= 1'b0;
        end else begin
            tick50 <= (tickCnt == 32'(TICK_CYC - 1));
            tickTenth <= 1'b0;
            tickSec <= 1'b0;
            if (tickCnt == 32'(TICK_CYC - 1)) begin
                tickCnt <= 32'h0;
                tenthDiv <= (tenthDiv == 2'h1) ? 2'h0 : tenthDiv + 2'h1;
                tickTenth <= (tenthDiv == 2'h1);
                secDiv <= (secDiv == 5'h13) ? 5'h0 : secDiv + 5'h1;
                tickSec <= (secDiv == 5'h13);
            end else begin
                tickCnt <= tickCnt + 32'h1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Position within the segment
    // -------------------------------------------------------------------
    logic [POS_W-1:0] segOffset, distRest;
    logic inBookZone, inEmArea, emPressed, transitReq;
    always_comb begin
        // Position is taken modulo the segment length, zero at start.
        segOffset = (segLength == '0) ? position : position % segLength;
        // Rest lies on a segment boundary: nearest edge distance.
        distRest = (segOffset > (segLength >> 1)) ?
                   segLength - segOffset : segOffset;
    end
    assign inBookZone = !flags[`TSS_F_REDBOOK] ||
                        (segOffset < bookZone);
    assign inEmArea = (distRest <= emArea);
    assign emPressed = flags[`TSS_F_NCEMERG] ? !fieldIn.emergBtn :
                       fieldIn.emergBtn;
    assign transitReq = fieldIn.radar ||
                        (!flags[`TSS_F_RADARONLY] &&
                         fieldIn.transitBtn);

    // -------------------------------------------------------------------
    // Emergency area timers
    // -------------------------------------------------------------------
    logic [15:0] emSecs, redSecs;
    logic emArmed;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emSecs <= 16'h0;
            redSecs <= 16'h0;
        end else if (!inEmArea) begin
            emSecs <= 16'h0;
            redSecs <= 16'h0;
        end else if (tickSec) begin
            if (emSecs < emTime) emSecs <= emSecs + 16'h1;
            if (redSecs < redunTime) redSecs <= redSecs + 16'h1;
        end
    end
    assign emArmed = inEmArea && (emSecs >= emTime) &&
                     (redSecs >= redunTime);

    // -------------------------------------------------------------------
    // Main sequencer
    // -------------------------------------------------------------------
    tss_state_t state;
    logic [15:0] phaseCnt, buzzCnt, blockCnt, handSteps;
    logic [POS_W-1:0] restPos;
    logic dirCcw, breakFlag, initDone;
    logic [15:0] stopNeed;
    assign stopNeed = (stopTime < `TSS_STOP_MIN) ? `TSS_STOP_MIN :
                      stopTime;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TSS_INIT;
            phaseCnt <= 16'h0;
            dirCcw <= 1'b1;
            rotOnRequest <= 1'b0;
            initDone <= 1'b0;
        end else begin
            case (state)
                TSS_INIT: begin
                    rotOnRequest <= flags[`TSS_F_STARTROT] ? 1'b1 :
                                    savedRotMode;
                    initDone <= 1'b1;
                    if (initDone) state <= TSS_IDLE;
                end
                TSS_IDLE: begin
                    phaseCnt <= 16'h0;
                    if (emArmed && emPressed) begin
                        state <= TSS_UNLOCKED;
                    end else if (fieldIn.doorDown &&
                                 flags[`TSS_F_FOLDING]) begin
                        state <= TSS_FOLDSTOP;
                    end else if (transitReq && inBookZone &&
                                 rotOnRequest) begin
                        state <= TSS_RUN;
                        dirCcw <= flags[`TSS_F_THREEWING] ? 1'b1 : dirCcw;
                    end
                end
                TSS_RUN: begin
                    if (fieldIn.doorDown && flags[`TSS_F_FOLDING]) begin
                        state <= TSS_FOLDSTOP;
                    end else if (fieldIn.edgeSafety ||
                                 (blockCnt >= reclose && reclose != 16'h0)) begin
                        state <= TSS_EDGESTOP;
                        phaseCnt <= 16'h0;
                    end else if (atRest && !transitReq) begin
                        state <= TSS_IDLE;
                    end
                end
                TSS_EDGESTOP: begin
                    if (tickTenth) phaseCnt <= phaseCnt + 16'h1;
                    if (phaseCnt >= stopNeed) begin
                        dirCcw <= !dirCcw;
                        state <= TSS_RUN;
                    end
                end
                TSS_FOLDSTOP: begin
                    if (!fieldIn.doorDown) state <= TSS_IDLE;
                end
                TSS_UNLOCKED: begin
                    if (tickSec) phaseCnt <= phaseCnt + 16'h1;
                    if (restoreTime != 16'h0 &&
                        phaseCnt >= restoreTime) begin
                        state <= TSS_IDLE;
                    end
                end
                default: state <= TSS_IDLE;
            endcase
        end
    end

    // Blocked time, in 50 ms units, restarts once movement resumes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blockCnt <= 16'h0;
        end else if (state != TSS_RUN || !fieldIn.blocked) begin
            blockCnt <= 16'h0;
        end else if (tick50 && blockCnt != 16'hFFFF) begin
            blockCnt <= blockCnt + 16'h1;
        end
    end

    // Buzzer: started by an edge trip, counted in tenths.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buzzCnt <= 16'h0;
        end else if (state == TSS_RUN && fieldIn.edgeSafety) begin
            buzzCnt <= buzzTime;
        end else if (tickTenth && buzzCnt != 16'h0) begin
            buzzCnt <= buzzCnt - 16'h1;
        end
    end

    // Hand movement while idle and nothing commanded is a break.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restPos <= '0;
            handSteps <= 16'h0;
            breakFlag <= 1'b0;
        end else if (state != TSS_IDLE || fieldIn.moveCmd) begin
            restPos <= position;
            handSteps <= 16'h0;
            breakFlag <= 1'b0;
        end else begin
            handSteps <= 16'((position > restPos) ? position - restPos :
                             restPos - position);
            if (handSteps > breakSteps) breakFlag <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------------
    logic canBook;
    assign canBook = (state == TSS_IDLE) && inBookZone;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlOut <= '0;
            transitStart <= 1'b0;
        end else begin
            ctrlOut.bookAccept <= canBook;
            ctrlOut.semGreen <= (flags[`TSS_F_SEMZONE] &&
                                 flags[`TSS_F_REDBOOK]) ? canBook :
                                (state == TSS_IDLE);
            ctrlOut.semRed <= (flags[`TSS_F_SEMZONE] &&
                               flags[`TSS_F_REDBOOK]) ? !canBook :
                              (state != TSS_IDLE);
            ctrlOut.buzzer <= (buzzCnt != 16'h0);
            ctrlOut.breakOut <= breakFlag;
            ctrlOut.brake <= (state == TSS_FOLDSTOP) &&
                             flags[`TSS_F_BRAKELOCK];
            ctrlOut.harpoon <= (state != TSS_UNLOCKED) ^
                               flags[`TSS_F_NCHARPOON];
            ctrlOut.motorRun <= (state == TSS_RUN);
            ctrlOut.motorCcw <= dirCcw;
            ctrlOut.emergArmed <= emArmed;
            transitStart <= (state == TSS_IDLE) && transitReq &&
                            inBookZone && rotOnRequest;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                `TSS_REG_FLAGS: regRdata <= {16'h0, flags};
                `TSS_REG_SEGS: regRdata <= {16'h0, segs};
                `TSS_REG_BOOKZONE: regRdata <= {16'h0, bookZone};
                `TSS_REG_EMAREA: regRdata <= {16'h0, emArea};
                `TSS_REG_EMTIME: regRdata <= {16'h0, emTime};
                `TSS_REG_BUZZTIME: regRdata <= {16'h0, buzzTime};
                `TSS_REG_STOPTIME: regRdata <= {16'h0, stopTime};
                `TSS_REG_BREAKSTEPS: regRdata <= {16'h0, breakSteps};
                `TSS_REG_REDUNTIME: regRdata <= {16'h0, redunTime};
                `TSS_REG_RESTORETIME: regRdata <= {16'h0, restoreTime};
                `TSS_REG_RECLOSE: regRdata <= {16'h0, reclose};
                `TSS_REG_STATUS: regRdata <= {25'h0, state, breakFlag,
                                              emArmed, rotOnRequest,
                                              inBookZone};
                default: regRdata <= 32'h0;
            endcase
        end else begin
            regRdata <= 32'h0;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ring_flags_a: assert property (flags[`TSS_F_RINGMASTER] &&
        flags[`TSS_F_RING19200]) else $error("ring flags cleared");
    stop_min_a: assert property ($rose(state == TSS_EDGESTOP) |->
        (state == TSS_EDGESTOP)[*8]) else $error("edge stop too short");
    edge_rev_a: assert property (state == TSS_EDGESTOP &&
        phaseCnt >= stopNeed |=> dirCcw != $past(dirCcw))
        else $error("no reversal after stop");
    book_zone_a: assert property (flags[`TSS_F_REDBOOK] &&
        segOffset >= bookZone |=> !ctrlOut.bookAccept)
        else $error("booking outside zone");
    em_area_a: assert property (!inEmArea |=> !ctrlOut.emergArmed)
        else $error("emergency armed outside area");
    radar_only_a: assert property (flags[`TSS_F_RADARONLY] &&
        !fieldIn.radar |=> !transitStart)
        else $error("button started transit");
    brake_fold_a: assert property (ctrlOut.brake |->
        $past(flags[`TSS_F_BRAKELOCK])) else $error("brake without lock");
    break_idle_a: assert property (state != TSS_IDLE |=> !breakFlag)
        else $error("break outside rest");
    buzz_start_a: assert property (state == TSS_RUN && fieldIn.edgeSafety &&
        buzzTime != 16'h0 |=> ##1 ctrlOut.buzzer)
        else $error("buzzer not started");
    edge_stop_c: cover property (state == TSS_EDGESTOP);
    unlock_c: cover property (state == TSS_UNLOCKED);
    break_c: cover property (breakFlag);
    fold_c: cover property (state == TSS_FOLDSTOP);
endmodule : turnstile_supervisor

`default_nettype wire

/* testbench/tss_partner.sv */
// Far-side model of the booth: motor mechanics, encoder and emergency button.
`timescale 1ns/1ps
`default_nettype none

module tss_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Drive from the supervisor
    input wire logic motorRun,
    input wire logic motorCcw,
    // Scenario controls
    input wire logic load,
    input wire logic [15:0] loadPos,
    input wire logic handStep,
    input wire logic pressed,
    input wire logic ncEmerg,
    input wire logic [15:0] segLen,
    // Encoder and button
    output logic [15:0] position,
    output logic atRest,
    output logic emergBtn
);
    // -------------------------------------------------------------------
    // Mechanics
    // -------------------------------------------------------------------
    logic [15:0] step;

    // A hand step moves one step in the motor's direction, not on top of it, so forcing shows with it idle.
    assign step = motorCcw ? 16'hFFFF : 16'h0001;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            position <= 16'h0000;
        end else if (load) begin
            position <= loadPos;
        end else if (motorRun || handStep) begin
            position <= position + step;
        end
    end

    assign atRest = !motorRun && ((position % segLen) == 16'h0000);
    // A normally closed contact opens when it is pressed.
    assign emergBtn = ncEmerg ? !pressed : pressed;
endmodule : tss_partner

`default_nettype wire

/* testbench/turnstile_supervisor_bench.sv */
// Self-checking bench for the turnstile supervisor.
`timescale 1ns/1ps
`default_nettype none

module turnstile_supervisor_bench;
    import tss_pkg::*;
    // -------------------------------------------------------------------
    // Signals and helpers
    // -------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic savedRotMode = 1'b0;
    logic load = 1'b0;
    logic [15:0] loadPos = 16'h0000;
    logic handStep = 1'b0;
    logic pressed = 1'b0;
    logic ncEmerg = 1'b0;
    logic [15:0] segLength = 16'h07D0;
    logic [15:0] position;
    logic atRest;
    logic emergBtn;
    logic transitStart;
    logic seen;
    logic dir;
    logic [31:0] rdv;
    tss_in_t fin = '0;
    tss_in_t fieldIn;
    tss_out_t ctrlOut;
    int bad_count = 0;
    int n_checks = 0;
    int unsigned off;
    localparam logic [15:0] DFLT [11] = '{16'h0600, 16'h0004, 16'h02BC,
        16'h01F4, 16'h000A, 16'h000F, 16'h000A, 16'h0064, 16'h0000,
        16'h001E, 16'h000A};

    assign fieldIn = {fin.transitBtn, fin.radar, emergBtn, fin[4:0]};

    turnstile_supervisor #(.TICK_CYC(10), .POS_W(16)) i_turnstile_supervisor (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .position(position), .segLength(segLength), .atRest(atRest),
        .savedRotMode(savedRotMode), .fieldIn(fieldIn), .ctrlOut(ctrlOut),
        .transitStart(transitStart));

    tss_partner i_tss_partner (
        .clk(clk), .rst(rst), .motorRun(ctrlOut.motorRun),
        .motorCcw(ctrlOut.motorCcw), .load(load), .loadPos(loadPos),
        .handStep(handStep), .pressed(pressed), .ncEmerg(ncEmerg),
        .segLen(segLength), .position(position), .atRest(atRest),
        .emergBtn(emergBtn));

    initial forever #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask : rd

    task automatic setPos(input logic [15:0] p);
        @(posedge clk);
        load <= 1'b1;
        loadPos <= p;
        fin.dirCw <= 1'($urandom_range(1));
        // A commanded move, so the jump is not taken as forcing.
        fin.moveCmd <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        @(posedge clk);
        fin.moveCmd <= 1'b0;
        cyc(3);
    endtask : setPos

    task automatic watch(input int n);
        seen = 1'b0;
        repeat (n) begin
            cyc(1);
            seen = seen | transitStart;
        end
    endtask : watch

    task automatic pulseRst;
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
    endtask : pulseRst

    function automatic logic inZone(input logic [15:0] p);
        return (p % 16'h07D0) < 16'h02BC;
    endfunction : inZone

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    initial begin
        #(20000 * 8);
        bad_count++;
        conclude();
    end

    initial begin
        off = $urandom(10108);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        savedRotMode <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd(8'(i * 4));
            chk(rdv, {16'h0000, DFLT[i]});
        end
        rd(8'h34);
        chk(rdv, 32'h00000000);
        rd(8'h2C);
        chk(rdv[1], 1'b1);
        chk(ctrlOut.harpoon, 1'b1);
        wr(8'h00, 32'h00000000);
        rd(8'h00);
        chk(rdv, 32'h00000600);
        // Zone edges first, then random places in random segments.
        wr(8'h00, 32'h00000603);
        for (int i = 0; i < 24; i++) begin
            off = (i < 2) ? 699 + i : $urandom_range(1999);
            setPos(16'($urandom_range(3) * 2000 + off));
            chk(ctrlOut.bookAccept, inZone(position));
            chk({ctrlOut.semGreen, ctrlOut.semRed},
                {inZone(position), !inZone(position)});
        end
        wr(8'h00, 32'h00000600);
        setPos(16'h05DC);
        chk(ctrlOut.bookAccept, 1'b1);
        // Stop time below the minimum must still give a full second.
        wr(8'h18, 32'h00000003);
        wr(8'h00, 32'h00000608);
        setPos(16'h0064);
        @(posedge clk) fin.transitBtn <= 1'b1;
        watch(8);
        chk(seen, 1'b0);
        @(posedge clk);
        fin.transitBtn <= 1'b0;
        fin.radar <= 1'b1;
        watch(8);
        chk(seen, 1'b1);
        @(posedge clk) fin.radar <= 1'b0;
        cyc(20);
        chk(ctrlOut.motorRun, 1'b1);
        dir = ctrlOut.motorCcw;
        @(posedge clk) fin.edgeSafety <= 1'b1;
        repeat (2) @(posedge clk);
        fin.edgeSafety <= 1'b0;
        cyc(20);
        chk(ctrlOut.buzzer, 1'b1);
        cyc(160);
        chk(ctrlOut.motorRun, 1'b0);
        cyc(100);
        chk(ctrlOut.buzzer, 1'b1);
        chk({ctrlOut.motorRun, ctrlOut.motorCcw}, {1'b1, !dir});
        cyc(50);
        chk(ctrlOut.buzzer, 1'b0);
        // A jam held for the re-closure time stops like an edge trip.
        @(posedge clk) fin.blocked <= 1'b1;
        cyc(85);
        chk(ctrlOut.motorRun, 1'b1);
        cyc(20);
        chk({ctrlOut.motorRun, ctrlOut.buzzer}, 2'h0);
        @(posedge clk) fin.blocked <= 1'b0;
        // Hand forcing: exactly the limit is tolerated, one more is not.
        pulseRst();
        setPos(16'h0FA0);
        @(posedge clk) handStep <= 1'b1;
        repeat (100) @(posedge clk);
        handStep <= 1'b0;
        cyc(4);
        chk(ctrlOut.breakOut, 1'b0);
        @(posedge clk) handStep <= 1'b1;
        repeat (1) @(posedge clk);
        handStep <= 1'b0;
        cyc(4);
        chk(ctrlOut.breakOut, 1'b1);
        // Folding door knocked down with brake lock selected.
        wr(8'h00, 32'h00000630);
        @(posedge clk) fin.doorDown <= 1'b1;
        cyc(3);
        chk({ctrlOut.brake, ctrlOut.motorRun}, 2'h2);
        @(posedge clk) fin.doorDown <= 1'b0;
        // Emergency area, arming time, NC button and auto-restore.
        @(posedge clk) savedRotMode <= 1'b0;
        pulseRst();
        wr(8'h24, 32'h00000001);
        wr(8'h00, 32'h000006C0);
        @(posedge clk) ncEmerg <= 1'b1;
        setPos(16'h20D0);
        cyc(1850);
        chk(ctrlOut.emergArmed, 1'b0);
        cyc(300);
        chk(ctrlOut.emergArmed, 1'b1);
        @(posedge clk) pressed <= 1'b1;
        repeat (3) @(posedge clk);
        pressed <= 1'b0;
        cyc(3);
        rd(8'h2C);
        chk(rdv[6:4], 3'h5);
        chk({rdv[1], ctrlOut.harpoon}, 2'h1);
        cyc(230);
        rd(8'h2C);
        chk(rdv[6:4], 3'h1);
        chk(ctrlOut.harpoon, 1'b0);
        setPos(16'h2260);
        chk(ctrlOut.emergArmed, 1'b0);
        conclude();
    end
endmodule : turnstile_supervisor_bench

`default_nettype wire
